/* File: core/lcdt_top.sv */
/*
  Display RAM addressing and display timing of a bitmap LCD driver:
  page/column auto-increment, line scan, display latch, clock source,
  frame polarity, field start, drive levels and power block enables.
  Assumes host access strobes come from logic on ref_clk_i, the display
  RAM answers ram_line_i for disp_line_o in the same cycle, and the
  mode pins and slave timing pins arrive asynchronously.
*/
//
// Summary of operation
// - column mode: column steps, wraps into next page
// - page mode: page steps, wraps into next column
// - last page, last column wraps both to zero
// - segment order bit reverses column to segment map
// - start line shown on first scanned common
// - start line may change any time to scroll
// - inverse and on/off act on latch only
// - oscillator only when master and select high
// - latch line data on display clock, independent
// - display clock drives common, polarity, field start
// - frame or line inversion chosen by setting
// - pin directions follow master and oscillator select
// - commons scan forward or reverse
// - four drive levels from data, scan, polarity
// - power blocks enabled only as master
// - four power bits enable the four blocks
// - each access steps selected address by one
`default_nettype none
`include "lcdt_defs.svh"

module lcdt_top
  import lcdt_pkg::*;
#(
  parameter int OSC_DIV = `LCDT_DCLK_PERIOD_NS / `LCDT_REF_PERIOD_NS
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic acc_stb_i,
  input wire logic incr_page_i,
  input wire logic page_set_i,
  input wire logic [4:0] page_val_i,
  input wire logic col_set_i,
  input wire logic [7:0] col_val_i,
  input wire logic seg_reverse_i,
  input wire logic com_reverse_i,
  input wire logic [6:0] start_line_i,
  input wire logic [6:0] duty_i,
  input wire logic inverse_i,
  input wire logic display_on_i,
  input wire logic line_invert_i,
  input wire logic [3:0] pwr_ctl_i,
  input wire logic [`LCDT_SEGS-1:0] ram_line_i,
  input wire logic master_i,
  input wire logic oscillator_select_i,
  input wire logic display_clock_pin_i,
  input wire logic frame_polarity_i,
  input wire logic display_off_line_n_i,
  input wire logic field_start_i,
  output logic display_clock_pin_o,
  output logic display_clock_pin_oe_o,
  output logic frame_polarity_o,
  output logic frame_polarity_oe_o,
  output logic display_off_line_n_o,
  output logic display_off_line_n_oe_o,
  output logic field_start_o,
  output logic field_start_oe_o,
  output logic [4:0] page_addr_o,
  output logic [7:0] col_addr_o,
  output logic [6:0] disp_line_o,
  output logic [2*`LCDT_SEGS-1:0] seg_lvl_o,
  output logic [2*`LCDT_COMS-1:0] com_lvl_o,
  output logic pwr_mult2_en_o,
  output logic pwr_mult1_en_o,
  output logic pwr_adj_en_o,
  output logic pwr_fol_en_o
);

  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);
  localparam logic [15:0] OSC_HALF = 16'(OSC_DIV / 2);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [`LCDT_SY_W-1:0] sy_d;
  logic [`LCDT_SY_W-1:0] sy_q;

  assign sy_d = {field_start_i, display_off_line_n_i, frame_polarity_i,
                 display_clock_pin_i, oscillator_select_i, master_i};

  lcdt_sync #(.W(`LCDT_SY_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(sy_d),
    .q_o(sy_q)
  );

  wire master_s = sy_q[`LCDT_SY_MASTER];
  wire osc_s = sy_q[`LCDT_SY_OSC];
  wire clk_s = sy_q[`LCDT_SY_CLK];
  wire fr_s = sy_q[`LCDT_SY_FR];
  wire dof_n_s = sy_q[`LCDT_SY_DOF];
  wire fs_s = sy_q[`LCDT_SY_FS];

  //////////////////////////////////////////////////////////////////////
  // host address counters

  logic [4:0] page_addr;
  logic [7:0] col_addr;
  lcdt_incr_t incr_dir;

  assign incr_dir = incr_page_i ? LCDT_INCR_PAGE : LCDT_INCR_COL;

  wire col_end = (col_addr == `LCDT_COL_LAST);
  wire page_end = (page_addr == `LCDT_PAGE_LAST);
  wire [7:0] col_inc = col_end ? `LCDT_COL_FIRST : col_addr + 8'h01;
  wire [4:0] page_inc = page_end ? `LCDT_PAGE_FIRST : page_addr + 5'h01;
  // column mode: page moves only when column wraps
  wire [7:0] col_step_c = col_inc;
  wire [4:0] page_step_c = col_end ? page_inc : page_addr;
  // page mode: column moves only when page wraps
  wire [4:0] page_step_p = page_inc;
  wire [7:0] col_step_p = page_end ? col_inc : col_addr;
  wire is_page = (incr_dir == LCDT_INCR_PAGE);
  // one step per access, direction from setting
  wire [7:0] col_step = is_page ? col_step_p : col_step_c;
  wire [4:0] page_step = is_page ? page_step_p : page_step_c;
  // explicit set wins over a same-cycle access
  wire [7:0] next_col = col_set_i ? col_val_i :
                        acc_stb_i ? col_step : col_addr;
  wire [4:0] next_page = page_set_i ? page_val_i :
                         acc_stb_i ? page_step : page_addr;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      col_addr <= `LCDT_COL_FIRST;
      page_addr <= `LCDT_PAGE_FIRST;
    end else begin
      col_addr <= next_col;
      page_addr <= next_page;
    end
  end

  assign col_addr_o = col_addr;
  assign page_addr_o = page_addr;

  //////////////////////////////////////////////////////////////////////
  // display clock source

  logic [15:0] osc_cnt;
  logic clk_prev;
  lcdt_src_t clk_src;

  // oscillator runs only as master with select high
  wire osc_run = master_s & osc_s;
  assign clk_src = osc_run ? LCDT_SRC_OSC : LCDT_SRC_PIN;
  wire osc_wrap = (osc_cnt == OSC_LAST);
  wire [15:0] next_osc = (!osc_run || osc_wrap) ? 16'h0000 :
                         osc_cnt + 16'h0001;
  wire osc_tick = osc_run & osc_wrap;
  // edge taken from the second sync stage, never the first
  wire pin_tick = (clk_src == LCDT_SRC_PIN) & clk_s & ~clk_prev;
  wire dclk_tick = osc_tick | pin_tick;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      osc_cnt <= 16'h0000;
      clk_prev <= 1'b0;
    end else begin
      osc_cnt <= next_osc;
      clk_prev <= clk_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // line scan and frame timing

  logic [6:0] line_cnt;
  logic fs_prev;
  logic fr;

  wire [6:0] duty_last = (duty_i == 7'h00) ? 7'h00 : duty_i - 7'h01;
  wire line_end = (line_cnt >= duty_last);
  wire fs_rise = fs_s & ~fs_prev;
  // slave realigns its scan to the master's field start
  wire slave_restart = ~master_s & fs_rise;
  wire frame_end = dclk_tick & line_end;
  wire [6:0] next_line = slave_restart ? `LCDT_LINE_FIRST :
                         !dclk_tick ? line_cnt :
                         line_end ? `LCDT_LINE_FIRST :
                         line_cnt + 7'h01;
  // frame inversion toggles per frame, line inversion per line
  wire fr_flip = line_invert_i ? dclk_tick : frame_end;
  wire next_fr = master_s ? (fr ^ fr_flip) : fr_s;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      line_cnt <= `LCDT_LINE_FIRST;
      fs_prev <= 1'b0;
      fr <= 1'b0;
    end else begin
      line_cnt <= next_line;
      fs_prev <= fs_s;
      fr <= next_fr;
    end
  end

  // start line may be rewritten any cycle; address follows
  wire [7:0] line_sum = {1'b0, start_line_i} + {1'b0, line_cnt};
  wire [7:0] line_mod = (line_sum >= `LCDT_LINES) ?
                        line_sum - `LCDT_LINES : line_sum;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      disp_line_o <= `LCDT_LINE_FIRST;
    end else begin
      disp_line_o <= line_mod[6:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // timing pins

  wire disp_on_eff = master_s ? display_on_i : dof_n_s;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      display_clock_pin_o <= 1'b0;
      display_clock_pin_oe_o <= 1'b0;
      frame_polarity_o <= 1'b0;
      frame_polarity_oe_o <= 1'b0;
      display_off_line_n_o <= 1'b0;
      display_off_line_n_oe_o <= 1'b0;
      field_start_o <= 1'b0;
      field_start_oe_o <= 1'b0;
    end else begin
      display_clock_pin_o <= osc_run & (osc_cnt < OSC_HALF);
      display_clock_pin_oe_o <= osc_run;
      frame_polarity_o <= next_fr;
      frame_polarity_oe_o <= master_s;
      display_off_line_n_o <= display_on_i;
      display_off_line_n_oe_o <= master_s;
      field_start_o <= master_s & frame_end;
      field_start_oe_o <= master_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // display latch and drive levels

  logic [`LCDT_SEGS-1:0] latch;
  logic [6:0] scan_line;

  // refresh reads only on display clock, never on host access
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      latch <= '0;
      scan_line <= `LCDT_LINE_FIRST;
    end else if (dclk_tick) begin
      latch <= ram_line_i;
      scan_line <= line_cnt;
    end
  end

  genvar k;
  generate
    for (k = 0; k < `LCDT_SEGS; k++) begin : g_seg
      // segment order select
      wire bit_sel = seg_reverse_i ? latch[`LCDT_SEGS-1-k] : latch[k];
      // inverse and blanking touch only the latch output
      wire seg_on = disp_on_eff & (bit_sel ^ inverse_i);
      wire lcdt_lvl_t lvl = {fr, seg_on};
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          seg_lvl_o[2*k +: 2] <= 2'h0;
        end else begin
          seg_lvl_o[2*k +: 2] <= lvl;
        end
      end
    end
    for (k = 0; k < `LCDT_COMS; k++) begin : g_com
      // forward scans first to last, reverse the other way
      wire [6:0] com_line = com_reverse_i ? `LCDT_COM_LAST - 7'(k) : 7'(k);
      wire com_hit = (scan_line == com_line);
      wire lcdt_lvl_t lvl = {fr, com_hit};
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          com_lvl_o[2*k +: 2] <= 2'h0;
        end else begin
          com_lvl_o[2*k +: 2] <= lvl;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // power block enables
  // host is expected to use only the listed combinations

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pwr_mult2_en_o <= 1'b0;
      pwr_mult1_en_o <= 1'b0;
      pwr_adj_en_o <= 1'b0;
      pwr_fol_en_o <= 1'b0;
    end else begin
      // slaves take supplies from the master
      pwr_mult2_en_o <= master_s & pwr_ctl_i[`LCDT_PWR_MULT2];
      pwr_mult1_en_o <= master_s & pwr_ctl_i[`LCDT_PWR_MULT1];
      pwr_adj_en_o <= master_s & pwr_ctl_i[`LCDT_PWR_ADJ];
      pwr_fol_en_o <= master_s & pwr_ctl_i[`LCDT_PWR_FOL];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  wire plain_acc = acc_stb_i & ~col_set_i & ~page_set_i;

  chk_col_step: assert property (
    plain_acc && !is_page && !col_end |=>
      col_addr == $past(col_addr) + 8'h01 &&
      page_addr == $past(page_addr))
    else $error("column step wrong");

  chk_col_wrap: assert property (
    plain_acc && !is_page && col_end && !page_end |=>
      col_addr == `LCDT_COL_FIRST &&
      page_addr == $past(page_addr) + 5'h01)
    else $error("column wrap wrong");

  chk_page_step: assert property (
    plain_acc && is_page && !page_end |=>
      page_addr == $past(page_addr) + 5'h01 &&
      col_addr == $past(col_addr))
    else $error("page step wrong");

  chk_full_wrap: assert property (
    plain_acc && col_end && page_end |=>
      col_addr == `LCDT_COL_FIRST && page_addr == `LCDT_PAGE_FIRST)
    else $error("full wrap wrong");

  chk_osc_gate: assert property (
    !osc_run |=> osc_cnt == 16'h0000 && !display_clock_pin_oe_o)
    else $error("oscillator ran while gated");

  chk_slave_pins: assert property (
    !master_s [*2] |=> !frame_polarity_oe_o && !field_start_oe_o &&
      !display_off_line_n_oe_o && !display_clock_pin_oe_o)
    else $error("slave drives a timing pin");

  chk_pwr_gate: assert property (
    !master_s |=> !pwr_mult2_en_o && !pwr_mult1_en_o &&
      !pwr_adj_en_o && !pwr_fol_en_o)
    else $error("power block on in slave");

  chk_fr_frame: assert property (
    master_s && !line_invert_i && dclk_tick && !line_end |=>
      fr == $past(fr))
    else $error("polarity moved mid frame");

  chk_fs_pulse: assert property (
    master_s && frame_end |=> field_start_o ##1 !field_start_o)
    else $error("field start not one cycle");

endmodule : lcdt_top

`default_nettype wire

/* File: core/lcdt_defs.svh */
/*
  Constants of the display address and timing block: address limits,
  line and output counts, clock figures, power bit and pin positions.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef LCDT_DEFS_SVH
`define LCDT_DEFS_SVH

`define LCDT_COL_FIRST 8'h00
`define LCDT_COL_LAST 8'hb3
`define LCDT_PAGE_FIRST 5'h00
`define LCDT_PAGE_LAST 5'h11
`define LCDT_LINES 8'h41
`define LCDT_LINE_FIRST 7'h00
`define LCDT_COM_LAST 7'h3f
`define LCDT_SEGS 180
`define LCDT_COMS 64
`define LCDT_REF_PERIOD_NS 10
`define LCDT_DCLK_PERIOD_NS 50000
`define LCDT_PWR_MULT2 3
`define LCDT_PWR_MULT1 2
`define LCDT_PWR_ADJ 1
`define LCDT_PWR_FOL 0
`define LCDT_SY_MASTER 0
`define LCDT_SY_OSC 1
`define LCDT_SY_CLK 2
`define LCDT_SY_FR 3
`define LCDT_SY_DOF 4
`define LCDT_SY_FS 5
`define LCDT_SY_W 6

`endif

/* File: core/lcdt_pkg.sv */
/*
  Types of the display address and timing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package lcdt_pkg;
  typedef logic [1:0] lcdt_lvl_t;
  typedef enum logic {LCDT_INCR_COL, LCDT_INCR_PAGE} lcdt_incr_t;
  typedef enum logic {LCDT_SRC_OSC, LCDT_SRC_PIN} lcdt_src_t;
endpackage : lcdt_pkg

`default_nettype wire

/* File: core/lcdt_sync.sv */
/*
  Two-flop synchroniser for pins from outside the clock domain.
  Assumes each bit is a slow level; no bus coherence across bits.
*/
`default_nettype none

module lcdt_sync #(
  parameter int W = 6
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds the second stage only
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : lcdt_sync

`default_nettype wire

/* File: testbench/lcdt_panel_model.sv */
/*
  Far side of the timing block: display RAM line read and a master chip
  that feeds clock and timing pins to a slave.
  Assumes ref_clk_i runs free; the bench resolves pins from the enables.
*/
`default_nettype none
`include "lcdt_defs.svh"

module lcdt_panel_model (
  input wire logic ref_clk_i,
  input wire logic drive_clk_i,
  input wire logic drive_tim_i,
  input wire logic [6:0] disp_line_i,
  output logic [`LCDT_SEGS-1:0] ram_line_o,
  output logic clk_o,
  output logic fr_o,
  output logic dof_n_o,
  output logic fs_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  //////////////////////////////////////////////////////////////////////
  // column 0 lit, so a reversed segment map shows at once
  assign ram_line_o = {{(`LCDT_SEGS-2){1'b0}}, disp_line_i[0], 1'b1};
  always @(posedge ref_clk_i) begin
    if (drive_clk_i || drive_tim_i) begin
      cnt <= cnt + 8'h01;
    end
  end
  // clock stands still when not fed; released fr shows the inverse, dof and fs read low
  assign clk_o = drive_clk_i ? cnt[3] : 1'b0;
  assign fr_o = drive_tim_i ? cnt[7] : ~cnt[7];
  assign dof_n_o = drive_tim_i;
  assign fs_o = drive_tim_i ? (cnt[6:0] == 7'h00) : 1'b0;
endmodule : lcdt_panel_model

`default_nettype wire

/* File: testbench/lcdt_top_test.sv */
/*
  Self-checking bench of the display address and timing block.
  Assumes the core files and the panel model are compiled before it.
*/
`default_nettype none
`include "lcdt_defs.svh"

module lcdt_top_test;
  import lcdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, nrst = 1'b0, acc = 1'b0, pset = 1'b0;
  logic cset = 1'b0, incp = 1'b0, segr = 1'b0, comr = 1'b0;
  logic inv = 1'b0, don = 1'b1, linv = 1'b0, mst = 1'b1, osel = 1'b1;
  logic dclk = 1'b0, dtim = 1'b0;
  logic [4:0] pval = 5'h00, page;
  logic [7:0] cval = 8'h00, col;
  logic [6:0] sline = 7'h00, duty = 7'h04, dline;
  logic [3:0] pwr = 4'h0;
  logic [`LCDT_SEGS-1:0] ram;
  logic [2*`LCDT_SEGS-1:0] seg;
  logic [2*`LCDT_COMS-1:0] com;
  logic m_clk, m_fr, m_dof, m_fs, ck_o, ck_oe, fr_o, fr_oe;
  logic dof_o, dof_oe, fs_o, fs_oe, e2, e1, ea, ef, pend = 1'b0;
  wire logic ck_w = ck_oe ? ck_o : m_clk;
  wire logic fr_w = fr_oe ? fr_o : m_fr;
  wire logic dof_w = dof_oe ? dof_o : m_dof;
  wire logic fs_w = fs_oe ? fs_o : m_fs;
  int n_errors = 0, samples_checked = 0, fsn, frn, ckn, lbad;
  logic [63:0] cm;
  logic [12:0] exp_q[$];
  logic [4:0] sp = 5'h00;
  logic [7:0] sc = 8'h00;
  // only the documented power combinations are used
  logic [3:0] pw_tab[6] = '{4'hf, 4'h7, 4'hb, 4'h3, 4'h1, 4'h0};

  always #5 ref_clk = ~ref_clk;

  lcdt_top #(.OSC_DIV(8)) u_lcdt_top (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .acc_stb_i(acc),
    .incr_page_i(incp), .page_set_i(pset), .page_val_i(pval),
    .col_set_i(cset), .col_val_i(cval), .seg_reverse_i(segr),
    .com_reverse_i(comr), .start_line_i(sline), .duty_i(duty),
    .inverse_i(inv), .display_on_i(don), .line_invert_i(linv),
    .pwr_ctl_i(pwr), .ram_line_i(ram), .master_i(mst),
    .oscillator_select_i(osel), .display_clock_pin_i(ck_w),
    .frame_polarity_i(fr_w), .display_off_line_n_i(dof_w),
    .field_start_i(fs_w), .display_clock_pin_o(ck_o),
    .display_clock_pin_oe_o(ck_oe), .frame_polarity_o(fr_o),
    .frame_polarity_oe_o(fr_oe), .display_off_line_n_o(dof_o),
    .display_off_line_n_oe_o(dof_oe), .field_start_o(fs_o),
    .field_start_oe_o(fs_oe), .page_addr_o(page), .col_addr_o(col),
    .disp_line_o(dline), .seg_lvl_o(seg), .com_lvl_o(com),
    .pwr_mult2_en_o(e2), .pwr_mult1_en_o(e1), .pwr_adj_en_o(ea),
    .pwr_fol_en_o(ef)
  );

  lcdt_panel_model u_lcdt_panel_model (
    .ref_clk_i(ref_clk), .drive_clk_i(dclk), .drive_tim_i(dtim),
    .disp_line_i(dline), .ram_line_o(ram), .clk_o(m_clk), .fr_o(m_fr),
    .dof_n_o(m_dof), .fs_o(m_fs)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] ex,
                     input logic [63:0] got);
    samples_checked++;
    if (ex !== got) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // k: 0 access, 1 page set, 2 column set; m: 1 page direction
  task automatic op(input int k, input int v, input int m);
    if (k == 1) sp = v[4:0];
    if (k == 2) sc = v[7:0];
    if (k == 0 && m == 0) begin
      sp = (sc != 8'hb3) ? sp : (sp == 5'h11) ? 5'h00 : sp + 5'h01;
      sc = (sc == 8'hb3) ? 8'h00 : sc + 8'h01;
    end
    if (k == 0 && m == 1) begin
      sc = (sp != 5'h11) ? sc : (sc == 8'hb3) ? 8'h00 : sc + 8'h01;
      sp = (sp == 5'h11) ? 5'h00 : sp + 5'h01;
    end
    exp_q.push_back({sp, sc});
    incp <= m[0];
    acc <= (k == 0);
    pset <= (k == 1);
    cset <= (k == 2);
    pval <= v[4:0];
    cval <= v[7:0];
    @(posedge ref_clk);
  endtask : op

  // gathers pulse, flip and scan counts over n cycles of steady state
  task automatic watch(input int n);
    logic fl, cl;
    int d;
    fsn = 0;
    frn = 0;
    ckn = 0;
    lbad = 0;
    cm = 64'h0;
    fl = fr_o;
    cl = ck_o;
    repeat (n) begin
      @(posedge ref_clk);
      fsn += int'(fs_o === 1'b1);
      frn += int'(fr_o !== fl);
      ckn += int'(ck_o !== cl);
      fl = fr_o;
      cl = ck_o;
      d = (int'(dline) + 65 - int'(sline)) % 65;
      lbad += int'(d >= int'(duty));
      for (int k = 0; k < 64; k++) begin
        if (com[2*k] === 1'b1) cm[k] = 1'b1;
      end
    end
  endtask : watch

  task automatic fr_follow;
    logic f0;
    int i;
    f0 = fr_w;
    i = 0;
    while (fr_w === f0 && i < 400) begin
      @(posedge ref_clk);
      i++;
    end
    if (i >= 400) begin
      chk("fr wait", 0, 1);
      complete_run();
    end
    repeat (40) @(posedge ref_clk);
    chk("seg polarity", fr_w, seg[1]);
    chk("com polarity", fr_w, com[1]);
  endtask : fr_follow

  // address results land one edge after the request is taken
  always @(posedge ref_clk) begin
    if (pend && exp_q.size() == 0) chk("queue empty", 1, 0);
    if (pend && exp_q.size() > 0) begin
      chk("address", exp_q.pop_front(), {page, col});
    end
    pend <= nrst & (acc | pset | cset);
  end

  initial begin
    #200000;
    chk("run time", 0, 1);
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    void'($urandom(32'h56b6));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("addr reset", 0, {page, col});
    op(1, 2, 0);
    op(2, 'hb2, 0);
    repeat (3) op(0, 0, 0);
    op(1, 17, 0);
    op(2, 'hb3, 0);
    op(0, 0, 0);
    op(1, 16, 1);
    op(2, 5, 1);
    repeat (2) op(0, 0, 1);
    op(1, 17, 1);
    op(2, 'hb3, 1);
    op(0, 0, 1);
    repeat (120) begin
      k = $urandom_range(0, 3);
      if (k == 3) k = 0;
      op(k, (k == 1) ? $urandom_range(0, 17) : $urandom_range(0, 'hb3),
         $urandom_range(0, 1));
    end
    acc <= 1'b0;
    pset <= 1'b0;
    cset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("queue left", 0, exp_q.size());
    foreach (pw_tab[i]) begin
      pwr <= pw_tab[i];
      repeat (3) @(posedge ref_clk);
      chk("power", pw_tab[i], {e2, e1, ea, ef});
    end
    chk("oe osc", 4'hf, {ck_oe, fr_oe, dof_oe, fs_oe});
    chk("dof on", 1, dof_o);
    repeat (60) @(posedge ref_clk);
    watch(128);
    chk("clock edges", 32, ckn);
    chk("field starts", 4, fsn);
    chk("frame flips", 4, frn);
    chk("commons", 64'hf, cm);
    chk("lines", 0, lbad);
    chk("seg first", 1, seg[0]);
    chk("seg last", 0, seg[2*`LCDT_SEGS-2]);
    inv <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk("inv first", 0, seg[0]);
    chk("inv last", 1, seg[2*`LCDT_SEGS-2]);
    inv <= 1'b0;
    segr <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk("rev first", 0, seg[0]);
    chk("rev last", 1, seg[2*`LCDT_SEGS-2]);
    comr <= 1'b1;
    linv <= 1'b1;
    sline <= 7'h3f;
    don <= 1'b0;
    repeat (70) @(posedge ref_clk);
    chk("dof off", 0, dof_o);
    watch(128);
    chk("line flips", 16, frn);
    chk("commons rev", 64'hf000000000000000, cm);
    chk("lines scrolled", 0, lbad);
    don <= 1'b1;
    linv <= 1'b0;
    osel <= 1'b0;
    dclk <= 1'b1;
    repeat (70) @(posedge ref_clk);
    chk("oe ext", 4'h7, {ck_oe, fr_oe, dof_oe, fs_oe});
    watch(128);
    chk("ext starts", 2, fsn);
    mst <= 1'b0;
    dtim <= 1'b1;
    pwr <= 4'hf;
    repeat (6) @(posedge ref_clk);
    chk("oe slave", 0, {ck_oe, fr_oe, dof_oe, fs_oe});
    chk("power slave", 0, {e2, e1, ea, ef});
    repeat (2) fr_follow();
    complete_run();
  end
endmodule : lcdt_top_test

`default_nettype wire
